// ===== design/cpu8_register_and_flag_set.sv
// Dedicated registers, condition codes and bank mapping of an 8-bit CPU core
//
// How it works
// - A 16-bit program counter gives the fetch address.
// - A 16-bit accumulator; byte operations touch only its low byte.
// - A 16-bit temporary accumulator is the second operand; byte ops use low byte.
// - A 16-bit index register modifies indexed effective addresses.
// - A 16-bit extra pointer addresses memory.
// - A 16-bit stack pointer points into the stack area.
// - Status word: upper byte is bank pointer, lower byte condition codes.
// - Half carry flags a carry or borrow between bits 3 and 4.
// - Interrupt enable one permits interrupts, zero blocks; reset clears it.
// - Level codes 00/01 level 1, 10 level 2, 11 level 3 none.
// - A request is serviced only if its level beats the held level.
// - Negative flag copies the result's most significant bit.
// - Zero flag set for a zero result, cleared otherwise.
// - Overflow flag marks two's-complement overflow.
// - Carry flag marks carry or borrow out of bit 7 in byte mode, bit 15 in word mode.
// - On shifts the carry flag takes the bit shifted out.
// - General registers are bytes in data memory, eight to a bank.
// - Eight banks with 128 bytes of RAM, sixteen with 256.
// - The bank pointer selects the bank general register accesses reach.
// - One 64 KiB space: I/O lowest, data above, program highest.
`timescale 1ns/1ps

module cpu8_register_and_flag_set (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    // Configuration
    input  wire logic                  ram_large,
    // Program counter control
    input  wire logic                  pc_inc,
    input  wire logic                  pc_load,
    input  wire logic [15:0]           pc_value,
    // Register writes
    input  wire logic                  wr_en,
    input  wire cpu8_regs_pkg::reg_sel_t wr_sel,
    input  wire logic                  wr_byte,
    input  wire logic [15:0]           wr_data,
    // Arithmetic
    input  wire logic                  alu_en,
    input  wire cpu8_regs_pkg::alu_op_t alu_op,
    input  wire logic                  alu_byte,
    // Address generation
    input  wire logic [7:0]            idx_disp,
    input  wire logic [2:0]            gp_index,
    // Interrupt request
    input  wire logic                  irq_req,
    input  wire logic [1:0]            irq_req_level,
    // Register contents
    output logic [15:0]                program_counter,
    output logic [15:0]                accumulator,
    output logic [15:0]                temp_acc,
    output logic [15:0]                index_reg,
    output logic [15:0]                extra_pointer,
    output logic [15:0]                stack_pointer,
    output logic [15:0]                program_status,
    // Decoded views
    output logic [7:0]                 bank_pointer,
    output logic [7:0]                 condition_codes,
    output logic [1:0]                 irq_level_code,
    output logic                       irq_accept,
    output logic [15:0]                indexed_addr,
    output logic [15:0]                gp_addr,
    output logic                       bank_valid,
    output cpu8_regs_pkg::area_t       fetch_area
);

    // ==========================================================
    // State
    logic [15:0] pc_reg,  pc_next;
    logic [15:0] acc_reg, acc_next;
    logic [15:0] tmp_reg, tmp_next;
    logic [15:0] idx_reg, idx_next;
    logic [15:0] ext_reg, ext_next;
    logic [15:0] sp_reg,  sp_next;
    logic [7:0]  bank_reg, bank_next;
    logic [7:0]  cc_reg,   cc_next;

    // ==========================================================
    // Arithmetic unit
    logic [16:0] res;
    logic [4:0]  half;
    logic        msb_a, msb_t, msb_r;
    logic        carry_out, shift_out, is_sub, arith;
    logic [15:0] a_op, t_op, r_val;

    always_comb
    begin
        a_op      = alu_byte ? {8'h00, acc_reg[7:0]} : acc_reg;
        t_op      = alu_byte ? {8'h00, tmp_reg[7:0]} : tmp_reg;
        res       = 17'h00000;
        half      = 5'h00;
        shift_out = 1'b0;
        is_sub    = 1'b0;
        arith     = 1'b0;
        case (alu_op)
            cpu8_regs_pkg::OP_ADD, cpu8_regs_pkg::OP_ADC:
            begin
                arith = 1'b1;
                res  = {1'b0, a_op} + {1'b0, t_op}
                     + {16'h0000, alu_op == cpu8_regs_pkg::OP_ADC && cc_reg[0]};
                half = {1'b0, a_op[3:0]} + {1'b0, t_op[3:0]}
                     + {4'h0, alu_op == cpu8_regs_pkg::OP_ADC && cc_reg[0]};
            end
            cpu8_regs_pkg::OP_SUB, cpu8_regs_pkg::OP_SBC, cpu8_regs_pkg::OP_CMP:
            begin
                arith  = 1'b1;
                is_sub = 1'b1;
                res  = {1'b0, a_op} - {1'b0, t_op}
                     - {16'h0000, alu_op == cpu8_regs_pkg::OP_SBC && cc_reg[0]};
                half = {1'b0, a_op[3:0]} - {1'b0, t_op[3:0]}
                     - {4'h0, alu_op == cpu8_regs_pkg::OP_SBC && cc_reg[0]};
            end
            cpu8_regs_pkg::OP_INC:
            begin
                arith = 1'b1;
                res   = {1'b0, a_op} + 17'h00001;
                half  = {1'b0, a_op[3:0]} + 5'h01;
            end
            cpu8_regs_pkg::OP_DEC:
            begin
                arith  = 1'b1;
                is_sub = 1'b1;
                res    = {1'b0, a_op} - 17'h00001;
                half   = {1'b0, a_op[3:0]} - 5'h01;
            end
            cpu8_regs_pkg::OP_AND: res = {1'b0, a_op & t_op};
            cpu8_regs_pkg::OP_OR:  res = {1'b0, a_op | t_op};
            cpu8_regs_pkg::OP_XOR: res = {1'b0, a_op ^ t_op};
            cpu8_regs_pkg::OP_SHL, cpu8_regs_pkg::OP_ROL:
            begin
                shift_out = alu_byte ? a_op[7] : a_op[15];
                res = {1'b0, a_op[14:0],
                       alu_op == cpu8_regs_pkg::OP_ROL ? cc_reg[0] : 1'b0};
            end
            cpu8_regs_pkg::OP_SHR, cpu8_regs_pkg::OP_ROR:
            begin
                shift_out = a_op[0];
                res = {1'b0, a_op >> 1};
                if (alu_op == cpu8_regs_pkg::OP_ROR)
                begin
                    if (alu_byte)
                        res[7] = cc_reg[0];
                    else
                        res[15] = cc_reg[0];
                end
            end
            default: res = {1'b0, a_op};
        endcase
        r_val = alu_byte ? {8'h00, res[7:0]} : res[15:0];
        // Byte mode takes carry and sign from bit 7, word mode from bit 15
        msb_a     = alu_byte ? a_op[7]  : a_op[15];
        msb_t     = alu_byte ? t_op[7]  : t_op[15];
        msb_r     = alu_byte ? res[7]   : res[15];
        carry_out = alu_byte ? (res[8] ^ (a_op[8] ^ t_op[8])) : res[16];
        if (alu_byte && (alu_op == cpu8_regs_pkg::OP_INC || alu_op == cpu8_regs_pkg::OP_DEC))
            carry_out = res[8];
    end

    // ==========================================================
    // Next state
    always_comb
    begin
        pc_next   = pc_reg;
        acc_next  = acc_reg;
        tmp_next  = tmp_reg;
        idx_next  = idx_reg;
        ext_next  = ext_reg;
        sp_next   = sp_reg;
        bank_next = bank_reg;
        cc_next   = cc_reg;
        if (pc_load)
            pc_next = pc_value;
        else if (pc_inc)
            pc_next = pc_reg + 16'h0001;
        if (alu_en)
        begin
            if (alu_op != cpu8_regs_pkg::OP_CMP)
            begin
                if (alu_byte)
                    acc_next = {acc_reg[15:8], r_val[7:0]};
                else
                    acc_next = r_val;
            end
            cc_next[cpu8_regs_pkg::CC_NEG]  = msb_r;
            cc_next[cpu8_regs_pkg::CC_ZERO] = (r_val == 16'h0000);
            if (arith)
            begin
                cc_next[cpu8_regs_pkg::CC_HALF]  = half[4];
                cc_next[cpu8_regs_pkg::CC_CARRY] = carry_out;
                if (alu_op == cpu8_regs_pkg::OP_INC || alu_op == cpu8_regs_pkg::OP_DEC)
                    cc_next[cpu8_regs_pkg::CC_OVF] = (msb_a != msb_r) && (msb_a == is_sub);
                else
                    cc_next[cpu8_regs_pkg::CC_OVF] = is_sub
                        ? (msb_a != msb_t) && (msb_r != msb_a)
                        : (msb_a == msb_t) && (msb_r != msb_a);
            end
            else if (alu_op inside {cpu8_regs_pkg::OP_SHL, cpu8_regs_pkg::OP_SHR,
                                    cpu8_regs_pkg::OP_ROL, cpu8_regs_pkg::OP_ROR})
                cc_next[cpu8_regs_pkg::CC_CARRY] = shift_out;
        end
        if (wr_en)
        begin
            case (wr_sel)
                cpu8_regs_pkg::SEL_ACC:
                    acc_next = wr_byte ? {acc_reg[15:8], wr_data[7:0]} : wr_data;
                cpu8_regs_pkg::SEL_TMP:
                    tmp_next = wr_byte ? {tmp_reg[15:8], wr_data[7:0]} : wr_data;
                cpu8_regs_pkg::SEL_IDX: idx_next = wr_data;
                cpu8_regs_pkg::SEL_EXT: ext_next = wr_data;
                cpu8_regs_pkg::SEL_SP:  sp_next  = wr_data;
                cpu8_regs_pkg::SEL_PS:
                begin
                    cc_next = wr_data[7:0];
                    if (!wr_byte)
                        bank_next = wr_data[15:8];
                end
                default: acc_next = acc_reg;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pc_reg   <= cpu8_regs_pkg::PC_RESET;
            acc_reg  <= 16'h0000;
            tmp_reg  <= 16'h0000;
            idx_reg  <= 16'h0000;
            ext_reg  <= 16'h0000;
            sp_reg   <= cpu8_regs_pkg::SP_RESET;
            bank_reg <= cpu8_regs_pkg::BANK_RESET;
            cc_reg   <= cpu8_regs_pkg::CC_RESET;
        end
        else
        begin
            pc_reg   <= pc_next;
            acc_reg  <= acc_next;
            tmp_reg  <= tmp_next;
            idx_reg  <= idx_next;
            ext_reg  <= ext_next;
            sp_reg   <= sp_next;
            bank_reg <= bank_next;
            cc_reg   <= cc_next;
        end
    end

    // ==========================================================
    // Interrupt gating
    logic [1:0] held_level, req_level;
    always_comb
    begin
        // Codes 00 and 01 both decode to level 1
        held_level = (irq_level_code == 2'h0) ? 2'h1 : irq_level_code;
        req_level  = (irq_req_level == 2'h0) ? 2'h1 : irq_req_level;
    end

    // Smaller level number wins; held level 1 admits nothing
    assign irq_accept = irq_req && cc_reg[cpu8_regs_pkg::CC_IEN]
                        && (req_level < held_level);

    // ==========================================================
    // Addressing
    logic [4:0]  bank_limit;
    logic [15:0] bank_base;

    assign bank_limit   = ram_large ? cpu8_regs_pkg::BANKS_LARGE
                                    : cpu8_regs_pkg::BANKS_SMALL;
    assign bank_valid   = ({3'h0, bank_reg[7:3]} < {3'h0, bank_limit});
    assign bank_base    = cpu8_regs_pkg::BANK_BASE + {8'h00, bank_reg[7:3], 3'h0};
    assign gp_addr      = bank_base + {13'h0, gp_index};
    assign indexed_addr = idx_reg + {{8{idx_disp[7]}}, idx_disp};

    always_comb
    begin
        if (pc_reg <= cpu8_regs_pkg::IO_TOP)
            fetch_area = cpu8_regs_pkg::AREA_IO;
        else if (pc_reg < cpu8_regs_pkg::PROG_BASE)
            fetch_area = cpu8_regs_pkg::AREA_DATA;
        else
            fetch_area = cpu8_regs_pkg::AREA_PROG;
    end

    // ==========================================================
    // Outputs
    assign program_counter = pc_reg;
    assign accumulator     = acc_reg;
    assign temp_acc        = tmp_reg;
    assign index_reg       = idx_reg;
    assign extra_pointer   = ext_reg;
    assign stack_pointer   = sp_reg;
    assign bank_pointer    = bank_reg;
    assign condition_codes = cc_reg;
    assign program_status  = {bank_reg, cc_reg};
    assign irq_level_code  = cc_reg[cpu8_regs_pkg::CC_LVL_HI:cpu8_regs_pkg::CC_LVL_LO];

endmodule // cpu8_register_and_flag_set

// ===== design/cpu8_regs_pkg.sv
// Constants and types for the CPU dedicated register set
package cpu8_regs_pkg;

    // ==========================================================
    // Widths
    localparam int WORD_W = 16;
    localparam int BYTE_W = 8;

    // ==========================================================
    // Program status field positions
    localparam int PS_BANK_HI = 15;
    localparam int PS_BANK_LO = 8;
    localparam int CC_HALF    = 7;
    localparam int CC_IEN     = 6;
    localparam int CC_LVL_HI  = 5;
    localparam int CC_LVL_LO  = 4;
    localparam int CC_NEG     = 3;
    localparam int CC_ZERO    = 2;
    localparam int CC_OVF     = 1;
    localparam int CC_CARRY   = 0;

    // ==========================================================
    // Reset values
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [15:0] SP_RESET = 16'h0000;
    localparam logic [7:0]  BANK_RESET = 8'h00;
    localparam logic [7:0]  CC_RESET = 8'h30;

    // ==========================================================
    // Memory map and banks
    localparam logic [15:0] BANK_BASE   = 16'h0100;
    localparam int          BANK_REGS   = 8;
    localparam logic [4:0]  BANKS_SMALL = 5'h08;
    localparam logic [4:0]  BANKS_LARGE = 5'h10;
    localparam logic [15:0] IO_TOP      = 16'h007f;
    localparam logic [15:0] PROG_BASE   = 16'h8000;

    // ==========================================================
    // Operations
    typedef enum logic [3:0] {
        OP_NONE, OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_AND, OP_OR, OP_XOR,
        OP_SHL, OP_SHR, OP_ROL, OP_ROR, OP_INC, OP_DEC, OP_CMP
    } alu_op_t;

    // Register select for writes
    typedef enum logic [2:0] {
        SEL_ACC, SEL_TMP, SEL_IDX, SEL_EXT, SEL_SP, SEL_PS
    } reg_sel_t;

    typedef enum logic [1:0] {
        AREA_IO, AREA_DATA, AREA_PROG
    } area_t;

endpackage

// ===== sim/cpu8_register_and_flag_set_test.sv
// Self-checking bench for the CPU register set
`timescale 1ns/1ps

module cpu8_register_and_flag_set_test;
    // ==========================================================
    // Signals
    logic clk = 1'b0, rst_n = 1'b0, ram_large = 1'b0, pc_inc = 1'b0, pc_load = 1'b0;
    logic wr_en = 1'b0, wr_byte = 1'b0, alu_en = 1'b0, alu_byte = 1'b0, irq_req = 1'b0;
    logic [15:0] pc_value = 16'h0000, wr_data = 16'h0000;
    logic [7:0] idx_disp = 8'h00;
    logic [2:0] gp_index = 3'h0;
    logic [1:0] irq_req_level = 2'h0;
    cpu8_regs_pkg::reg_sel_t wr_sel = cpu8_regs_pkg::SEL_ACC;
    cpu8_regs_pkg::alu_op_t alu_op = cpu8_regs_pkg::OP_NONE;
    logic [15:0] program_counter, accumulator, temp_acc, index_reg, extra_pointer;
    logic [15:0] stack_pointer, program_status, indexed_addr, gp_addr;
    logic [7:0] bank_pointer, condition_codes;
    logic [1:0] irq_level_code;
    logic irq_accept, bank_valid;
    cpu8_regs_pkg::area_t fetch_area;
    int n_mismatch = 0;
    int n_compared = 0;
    logic [31:0] seed = 32'h5ae9;
    // Boundary operands: carry, overflow, half carry, borrow
    logic [7:0] ta [6] = '{8'hff, 8'h7f, 8'h80, 8'h0f, 8'h00, 8'h08};
    logic [7:0] tb [6] = '{8'h01, 8'h01, 8'h80, 8'h01, 8'h01, 8'h08};
    logic [15:0] pcs [6] = '{16'h0000, 16'h007f, 16'h0080, 16'h7fff, 16'h8000, 16'hffff};

    always #50 clk = ~clk;

    cpu8_register_and_flag_set cpu8_register_and_flag_set_inst (
        .clk(clk), .rst_n(rst_n), .ram_large(ram_large), .pc_inc(pc_inc), .pc_load(pc_load),
        .pc_value(pc_value), .wr_en(wr_en), .wr_sel(wr_sel), .wr_byte(wr_byte),
        .wr_data(wr_data), .alu_en(alu_en), .alu_op(alu_op), .alu_byte(alu_byte),
        .idx_disp(idx_disp), .gp_index(gp_index), .irq_req(irq_req),
        .irq_req_level(irq_req_level), .program_counter(program_counter),
        .accumulator(accumulator), .temp_acc(temp_acc), .index_reg(index_reg),
        .extra_pointer(extra_pointer), .stack_pointer(stack_pointer),
        .program_status(program_status), .bank_pointer(bank_pointer),
        .condition_codes(condition_codes), .irq_level_code(irq_level_code),
        .irq_accept(irq_accept), .indexed_addr(indexed_addr), .gp_addr(gp_addr),
        .bank_valid(bank_valid), .fetch_area(fetch_area));

    // ==========================================================
    // Expectations and helpers
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    function automatic logic [1:0] lvl(input logic [1:0] c);
        return (c == 2'h3) ? 2'h3 : ((c == 2'h2) ? 2'h2 : 2'h1);
    endfunction

    // Returns {H, N, Z, V, C, result}
    function automatic logic [12:0] add8(input logic [7:0] a, b, input logic sub);
        logic [8:0] s;
        logic h;
        logic v;
        s = sub ? ({1'b0, a} - {1'b0, b}) : ({1'b0, a} + {1'b0, b});
        h = sub ? (a[3:0] < b[3:0]) : ({1'b0, a[3:0]} + {1'b0, b[3:0]} > 5'h0f);
        v = (sub ? (a[7] != b[7]) : (a[7] == b[7])) && (s[7] != a[7]);
        return {h, s[7], s[7:0] == 8'h00, v, s[8], s[7:0]};
    endfunction

    function automatic cpu8_regs_pkg::area_t area_of(input logic [15:0] a);
        if (a <= 16'h007f)
            return cpu8_regs_pkg::AREA_IO;
        return (a < 16'h8000) ? cpu8_regs_pkg::AREA_DATA : cpu8_regs_pkg::AREA_PROG;
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input cpu8_regs_pkg::reg_sel_t s, input logic [15:0] d, input logic b);
        @(posedge clk);
        wr_en <= 1'b1;
        wr_sel <= s;
        wr_data <= d;
        wr_byte <= b;
        @(posedge clk);
        wr_en <= 1'b0;
        #1;
    endtask

    task automatic alu(input cpu8_regs_pkg::alu_op_t op);
        @(posedge clk);
        alu_en <= 1'b1;
        alu_op <= op;
        alu_byte <= 1'b1;
        @(posedge clk);
        alu_en <= 1'b0;
        #1;
    endtask

    // Load and increment together: load must win
    task automatic pcl(input logic [15:0] v);
        @(posedge clk);
        pc_load <= 1'b1;
        pc_inc <= 1'b1;
        pc_value <= v;
        @(posedge clk);
        pc_load <= 1'b0;
        pc_inc <= 1'b0;
        #1;
    endtask

    task automatic tally_and_finish;
        $display("Compared %0d, mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ==========================================================
    // Sequence
    initial
    begin
        logic [7:0] a, b;
        logic [12:0] e;
        logic [15:0] g;
        logic take;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        check(program_status, 16'h0030);
        pcl(16'hfffe);
        @(posedge clk);
        pc_inc <= 1'b1;
        repeat (2) @(posedge clk);
        pc_inc <= 1'b0;
        #1;
        check(program_counter, 16'h0000);
        foreach (pcs[i])
        begin
            pcl(pcs[i]);
            check(program_counter, pcs[i]);
            check({14'h0, fetch_area}, {14'h0, area_of(pcs[i])});
        end
        seed = xs(seed);
        wr(cpu8_regs_pkg::SEL_EXT, seed[15:0], 1'b0);
        check(extra_pointer, seed[15:0]);
        wr(cpu8_regs_pkg::SEL_SP, seed[31:16], 1'b0);
        check(stack_pointer, seed[31:16]);
        wr(cpu8_regs_pkg::SEL_IDX, 16'h1000, 1'b0);
        check(index_reg, 16'h1000);
        @(posedge clk);
        idx_disp <= 8'h80;
        #1;
        check(indexed_addr, 16'h0f80);
        wr(cpu8_regs_pkg::SEL_ACC, 16'h1234, 1'b0);
        wr(cpu8_regs_pkg::SEL_ACC, 16'hff56, 1'b1);
        check(accumulator, 16'h1256);
        wr(cpu8_regs_pkg::SEL_TMP, 16'h1234, 1'b0);
        wr(cpu8_regs_pkg::SEL_TMP, 16'hff56, 1'b1);
        check(temp_acc, 16'h1256);
        for (int i = 0; i < 14; i++)
        begin
            seed = xs(seed);
            a = (i < 6) ? ta[i] : seed[7:0];
            b = (i < 6) ? tb[i] : seed[15:8];
            for (int s = 0; s < 2; s++)
            begin
                e = add8(a, b, s[0]);
                wr(cpu8_regs_pkg::SEL_ACC, {8'ha5, a}, 1'b0);
                wr(cpu8_regs_pkg::SEL_TMP, {8'h3c, b}, 1'b0);
                alu(s[0] ? cpu8_regs_pkg::OP_SUB : cpu8_regs_pkg::OP_ADD);
                check(accumulator, {8'ha5, e[7:0]});
                check({15'h0, condition_codes[7]}, {15'h0, e[12]});
                check({14'h0, condition_codes[3:2]}, {14'h0, e[11:10]});
                check({15'h0, condition_codes[1]}, {15'h0, e[9]});
                check({15'h0, condition_codes[0]}, {15'h0, e[8]});
            end
            wr(cpu8_regs_pkg::SEL_ACC, {8'h00, a}, 1'b0);
            alu(cpu8_regs_pkg::OP_SHL);
            check({15'h0, condition_codes[0]}, {15'h0, a[7]});
            check(accumulator, {8'h00, a[6:0], 1'b0});
            wr(cpu8_regs_pkg::SEL_ACC, {8'h00, b}, 1'b0);
            alu(cpu8_regs_pkg::OP_SHR);
            check({15'h0, condition_codes[0]}, {15'h0, b[0]});
        end
        @(posedge clk);
        irq_req <= 1'b1;
        for (int k = 0; k < 32; k++)
        begin
            wr(cpu8_regs_pkg::SEL_PS, {8'h00, 1'b0, k[4], k[3:2], 4'h0}, 1'b1);
            @(posedge clk);
            irq_req_level <= k[1:0];
            #1;
            take = k[4] && lvl(k[1:0]) < lvl(k[3:2]);
            check({15'h0, irq_accept}, {15'h0, take});
            check({14'h0, irq_level_code}, {14'h0, k[3:2]});
        end
        for (int k = 0; k < 64; k++)
        begin
            seed = xs(seed);
            wr(cpu8_regs_pkg::SEL_PS, {k[4:0], seed[2:0], 8'h30}, 1'b0);
            @(posedge clk);
            ram_large <= k[5];
            gp_index <= seed[5:3];
            #1;
            g = 16'h0100 + {8'h00, k[4:0], 3'h0} + {13'h0, seed[5:3]};
            check(gp_addr, g);
            check({8'h00, bank_pointer}, {8'h00, k[4:0], seed[2:0]});
            check({15'h0, bank_valid}, {15'h0, k[4:0] < (k[5] ? 5'h10 : 5'h08)});
            check(program_status, {k[4:0], seed[2:0], 8'h30});
        end
        // Random traffic; the checker judges it
        repeat (3000)
        begin
            @(posedge clk);
            seed = xs(seed);
            {pc_inc, pc_load, wr_en, wr_byte, alu_en, alu_byte, irq_req, ram_large} <= seed[7:0];
            wr_sel <= cpu8_regs_pkg::reg_sel_t'(seed[10:8] % 3'h6);
            alu_op <= cpu8_regs_pkg::alu_op_t'(seed[14:11] % 4'hf);
            {irq_req_level, gp_index} <= seed[19:15];
            idx_disp <= seed[27:20];
            pc_value <= seed[31:16];
            wr_data <= seed[15:0];
        end
        @(posedge clk);
        {pc_inc, pc_load, wr_en, alu_en} <= 4'h0;
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check(program_status, 16'h0030);
        check(program_counter, 16'h0000);
        @(posedge clk);
        rst_n <= 1'b1;
        pc_inc <= 1'b1;
        @(posedge clk);
        pc_inc <= 1'b0;
        #1;
        check(program_counter, 16'h0001);
        tally_and_finish();
    end
endmodule // cpu8_register_and_flag_set_test

// ===== sim/cpu8_regs_monitor.sv
// Port-level checks for the CPU register set
`timescale 1ns/1ps

// ==========================================================
// Checker
module cpu8_regs_monitor (
    // Clock and reset
    input wire logic                     clk,
    input wire logic                     rst_n,
    // Controls
    input wire logic                     ram_large,
    input wire logic                     pc_inc,
    input wire logic                     pc_load,
    input wire logic                     wr_en,
    input wire cpu8_regs_pkg::reg_sel_t  wr_sel,
    input wire logic                     alu_en,
    input wire cpu8_regs_pkg::alu_op_t   alu_op,
    input wire logic                     alu_byte,
    input wire logic [2:0]               gp_index,
    input wire logic                     irq_req,
    input wire logic [1:0]               irq_req_level,
    // Observed outputs
    input wire logic [15:0]              program_counter,
    input wire logic [15:0]              accumulator,
    input wire logic [15:0]              program_status,
    input wire logic [7:0]               bank_pointer,
    input wire logic [7:0]               condition_codes,
    input wire logic [1:0]               irq_level_code,
    input wire logic                     irq_accept,
    input wire logic [15:0]              gp_addr,
    input wire logic                     bank_valid,
    input wire cpu8_regs_pkg::area_t     fetch_area
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // Byte result lands in the accumulator; same-cycle writes win, so skip those
    logic byte_op;
    assign byte_op = alu_en && alu_byte && alu_op != cpu8_regs_pkg::OP_NONE
        && alu_op != cpu8_regs_pkg::OP_CMP
        && !(wr_en && (wr_sel == cpu8_regs_pkg::SEL_ACC || wr_sel == cpu8_regs_pkg::SEL_PS));

    function automatic logic [1:0] lvl(input logic [1:0] c);
        return (c == 2'h3) ? 2'h3 : ((c == 2'h2) ? 2'h2 : 2'h1);
    endfunction

    chk_pc_step: assert property (pc_inc && !pc_load
        |=> program_counter == $past(program_counter) + 16'h0001)
        else $error("pc did not step");
    chk_ps_split: assert property (
        program_status == {bank_pointer, condition_codes})
        else $error("status halves disagree");
    chk_reset_codes: assert property (disable iff (1'b0)
        !rst_n ##1 !rst_n |-> condition_codes == 8'h30)
        else $error("reset codes wrong");
    chk_irq_gate: assert property (irq_accept == (irq_req
        && condition_codes[6] && lvl(irq_req_level) < lvl(irq_level_code)))
        else $error("irq accept wrong");
    chk_flag_nz: assert property (byte_op |=>
        condition_codes[2] == (accumulator[7:0] == 8'h00) && condition_codes[3] == accumulator[7])
        else $error("n or z flag wrong");
    chk_high_kept: assert property (byte_op |=> $stable(accumulator[15:8]))
        else $error("byte op touched high byte");
    chk_bank_addr: assert property (gp_addr == 16'h0100
        + {8'h00, bank_pointer[7:3], 3'h0} + {13'h0, gp_index})
        else $error("bank address wrong");
    chk_bank_limit: assert property (bank_valid ==
        (bank_pointer[7:3] < (ram_large ? 5'h10 : 5'h08)))
        else $error("bank limit wrong");
    chk_fetch_map: assert property (fetch_area ==
        ((program_counter <= 16'h007f) ? cpu8_regs_pkg::AREA_IO
        : ((program_counter < 16'h8000) ? cpu8_regs_pkg::AREA_DATA : cpu8_regs_pkg::AREA_PROG)))
        else $error("fetch area wrong");
endmodule // cpu8_regs_monitor

bind cpu8_register_and_flag_set cpu8_regs_monitor cpu8_regs_monitor_inst (
    .clk(clk), .rst_n(rst_n), .ram_large(ram_large), .pc_inc(pc_inc), .pc_load(pc_load),
    .wr_en(wr_en), .wr_sel(wr_sel), .alu_en(alu_en), .alu_op(alu_op), .alu_byte(alu_byte),
    .gp_index(gp_index), .irq_req(irq_req), .irq_req_level(irq_req_level),
    .program_counter(program_counter), .accumulator(accumulator),
    .program_status(program_status), .bank_pointer(bank_pointer),
    .condition_codes(condition_codes), .irq_level_code(irq_level_code),
    .irq_accept(irq_accept), .gp_addr(gp_addr), .bank_valid(bank_valid),
    .fetch_area(fetch_area));
